// *** core/auto_reload_pwm_timer.sv ***
// eight-bit auto-reload timer with four PWM outputs and two captures
`timescale 1ns/1ps
module auto_reload_pwm_timer #(
	parameter int PWM_CH = 4,
	parameter int CAP_CH = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// register writes
	input wire art_pkg::reg_wr_t ctrlWr,
	input wire art_pkg::reg_wr_t counterWr,
	input wire art_pkg::reg_wr_t reloadWr,
	input wire art_pkg::reg_wr_t pwmCtrlWr,
	input wire art_pkg::reg_wr_t captureCtrlWr,
	input wire logic [3:0] dutyWrEn,
	input wire logic [7:0] dutyWrData,
	// read strobes with side effects
	input wire logic ctrlRd,
	input wire logic [1:0] captureRd,
	// system and pins
	input wire logic haltMode,
	input wire logic extClkIn,
	input wire logic [1:0] captureIn,
	// register views
	output logic [7:0] ctrlStatus_q,
	output logic [7:0] counter_q,
	output logic [7:0] autoReload_q,
	output logic [7:0] pwmCtrl_q,
	output logic [7:0] captureCtrl_q,
	output logic [7:0] captureVal0_q,
	output logic [7:0] captureVal1_q,
	// pins and requests
	output art_pkg::pwm_pins_t pwmPins_q,
	output logic overflowIrq_q,
	output logic [1:0] captureIrq_q,
	output logic wakeUp_q
);
	import art_pkg::*;
	default clocking astClk @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (PWM_CH != 4) begin : g_badPwm
		$error("PWM_CH must be 4: control fields are four bits wide");
	end
	if (CAP_CH != 2) begin : g_badCap
		$error("CAP_CH must be 2: capture fields are two bits wide");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic extRise;
	logic [1:0] capRise;
	logic [1:0] capFall;

	edge_sync u_extSync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pinIn(extClkIn),
		.rise(extRise),
		.fall()
	);

	for (genvar c = 0; c < 2; c++) begin : g_capSync
		edge_sync u_capSync (
			.core_clk(core_clk),
			.sys_rst(sys_rst),
			.pinIn(captureIn[c]),
			.rise(capRise[c]),
			.fall(capFall[c])
		);
	end

	// ----------------------------------------------------------------
	// prescaler and counter tick
	// ----------------------------------------------------------------
	logic [6:0] pre_q;
	logic [6:0] tapMask;
	logic [2:0] divSel;
	logic running;
	logic inTick;
	logic preTick;
	logic cntTick;
	logic overflow;
	logic forceLoad;

	assign divSel = ctrlStatus_q[CSR_DIV_HI:CSR_DIV_LO];
	assign tapMask = 7'((8'h01 << divSel) - 8'h01);
	// halt also freezes the count so no spurious external ticks land
	assign running = ctrlStatus_q[CSR_TCE_BIT] & ~haltMode; // [R06]
	assign inTick = ctrlStatus_q[CSR_INCLK_BIT] ? extRise : 1'b1; // [R05]
	assign preTick = running & inTick;
	assign cntTick = preTick & ((pre_q & tapMask) == tapMask); // [R04]
	assign overflow = cntTick & (counter_q == CNT_TOP);
	assign forceLoad = ctrlWr.en & ctrlWr.data[CSR_FORCE_RELOAD_BIT]
		& ctrlWr.data[CSR_TCE_BIT];

	// prescaler is internal only, no view port exists [R09]
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pre_q <= PRE_RESET; // [R07]
		end else if (counterWr.en || forceLoad) begin
			pre_q <= PRE_RESET; // [R08]
		end else if (preTick) begin
			pre_q <= pre_q + 7'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			counter_q <= REG_RESET; // [R07]
		end else if (counterWr.en) begin
			counter_q <= counterWr.data; // [R02] [R08]
		end else if (forceLoad) begin
			counter_q <= autoReload_q; // [R08]
		end else if (overflow) begin
			counter_q <= autoReload_q; // [R03] [R13] [R18]
		end else if (cntTick) begin
			counter_q <= counter_q + 8'h01; // [R01]
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			autoReload_q <= REG_RESET;
		end else if (reloadWr.en) begin
			autoReload_q <= reloadWr.data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pwmCtrl_q <= REG_RESET;
		end else if (pwmCtrlWr.en) begin
			pwmCtrl_q <= pwmCtrlWr.data;
		end
	end

	// control bits; force reload never stored [R27]
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrlStatus_q[7:1] <= REG_RESET[7:1]; // [R07]
		end else if (ctrlWr.en) begin
			ctrlStatus_q[7:3] <= ctrlWr.data[7:3];
			ctrlStatus_q[CSR_FORCE_RELOAD_BIT] <= 1'b0; // [R27]
			ctrlStatus_q[CSR_OIE_BIT] <= ctrlWr.data[CSR_OIE_BIT];
		end
	end

	// overflow flag: a set in the reading cycle wins [R17] [R25]
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrlStatus_q[CSR_OVF_BIT] <= 1'b0;
		end else if (overflow) begin
			ctrlStatus_q[CSR_OVF_BIT] <= 1'b1; // [R17]
		end else if (ctrlRd) begin
			ctrlStatus_q[CSR_OVF_BIT] <= 1'b0; // [R25]
		end
	end

	// ----------------------------------------------------------------
	// duty and hidden compare registers
	// ----------------------------------------------------------------
	logic [7:0] duty_q [4];
	logic [7:0] cmp_q [4];

	for (genvar p = 0; p < 4; p++) begin : g_duty
		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				duty_q[p] <= REG_RESET;
			end else if (dutyWrEn[p]) begin
				duty_q[p] <= dutyWrData;
			end
		end

		// double buffer avoids glitches on duty changes [R10]
		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				cmp_q[p] <= REG_RESET;
			end else if (overflow) begin
				cmp_q[p] <= duty_q[p]; // [R10]
			end
		end
	end

	// ----------------------------------------------------------------
	// PWM pins
	// ----------------------------------------------------------------
	logic [3:0] pwmLevel;

	// polarity applies at once; level is high while counter is at or below compare, inverted by polarity [R14]
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			pwmLevel[p] = (counter_q <= cmp_q[p])
				^ pwmCtrl_q[PWMC_POL_LO + p]; // [R26]
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pwmPins_q <= '0;
		end else begin
			pwmPins_q.oe <= pwmCtrl_q[PWMC_OE_LO +: 4]; // [R12]
			if (!haltMode) begin // [R11]
				pwmPins_q.level <= pwmLevel & pwmCtrl_q[PWMC_OE_LO +: 4];
			end
		end
	end

	// ----------------------------------------------------------------
	// input capture
	// ----------------------------------------------------------------
	logic [1:0] capEvent;
	logic [1:0] capFlag;
	logic [1:0] capLoad;

	assign capFlag = captureCtrl_q[ICS_FLAG_LO +: 2];
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			capEvent[c] = captureCtrl_q[ICS_EDGE_LO + c]
				? capRise[c] : capFall[c]; // [R21]
			// a read in the same cycle unblocks the transfer [R22]
			capLoad[c] = capEvent[c] & (~capFlag[c] | captureRd[c]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			captureVal0_q <= REG_RESET;
			captureVal1_q <= REG_RESET;
		end else begin
			if (capLoad[0]) begin
				captureVal0_q <= counter_q; // [R20]
			end
			if (capLoad[1]) begin
				captureVal1_q <= counter_q; // [R20]
			end
		end
	end

	// reserved bits stay zero; flags set over read clear [R22]
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			captureCtrl_q <= REG_RESET;
		end else begin
			if (captureCtrlWr.en) begin
				captureCtrl_q[5:2] <= captureCtrlWr.data[5:2];
			end
			for (int c = 0; c < 2; c++) begin
				if (capLoad[c]) begin
					captureCtrl_q[ICS_FLAG_LO + c] <= 1'b1; // [R20]
				end else if (captureRd[c]) begin
					captureCtrl_q[ICS_FLAG_LO + c] <= 1'b0; // [R22]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// requests and wake-up
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			overflowIrq_q <= 1'b0;
			captureIrq_q <= 2'b00;
			wakeUp_q <= 1'b0;
		end else begin
			overflowIrq_q <= ctrlStatus_q[CSR_OVF_BIT]
				& ctrlStatus_q[CSR_OIE_BIT]; // [R17]
			captureIrq_q <= capFlag & captureCtrl_q[ICS_IE_LO +: 2]; // [R23]
			wakeUp_q <= (ctrlStatus_q[CSR_OVF_BIT] & ctrlStatus_q[CSR_OIE_BIT])
				| |(capFlag & captureCtrl_q[ICS_IE_LO +: 2]); // [R24]
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_CNT_STEP: assert property ( // [R01]
		cntTick && !overflow && !counterWr.en && !forceLoad
		|=> counter_q == $past(counter_q) + 8'h01)
		else $error("counter did not step on tick");
	AST_RELOAD: assert property ( // [R03]
		overflow && !counterWr.en && !forceLoad && !reloadWr.en
		|=> counter_q == autoReload_q && ctrlStatus_q[CSR_OVF_BIT])
		else $error("overflow did not reload counter or set flag");
	AST_FROZEN: assert property ( // [R06]
		!ctrlStatus_q[CSR_TCE_BIT] && !counterWr.en && !forceLoad
		|=> $stable(counter_q) && $stable(pre_q))
		else $error("counter moved while disabled");
	AST_CAR_WRITE: assert property ( // [R08]
		counterWr.en |=> counter_q == $past(counterWr.data)
		&& pre_q == PRE_RESET)
		else $error("counter write did not load or clear prescaler");
	AST_DIV_TAP: assert property ( // [R04]
		running && !ctrlStatus_q[CSR_INCLK_BIT] && divSel == 3'h1
		&& !counterWr.en && !forceLoad && !ctrlWr.en
		&& counter_q != CNT_TOP ##1 running && !counterWr.en && !forceLoad
		&& !ctrlWr.en && counter_q != CNT_TOP
		|=> counter_q == $past(counter_q, 2) + 8'h01)
		else $error("divide by two did not step once per two cycles");
	AST_CMP_LOAD: assert property ( // [R10]
		overflow && !dutyWrEn[0] |=> cmp_q[0] == duty_q[0])
		else $error("hidden compare not reloaded at overflow");
	AST_HALT_HOLD: assert property ( // [R11]
		haltMode |=> $stable(pwmPins_q.level))
		else $error("PWM pins changed in halt");
	AST_POLARITY: assert property ( // [R26]
		!haltMode && pwmCtrl_q[PWMC_OE_LO]
		|=> pwmPins_q.level[0] == ($past(counter_q) <= $past(cmp_q[0])
		^ $past(pwmCtrl_q[PWMC_POL_LO])))
		else $error("PWM level does not follow compare and polarity");
	AST_FORCE_RELOAD_ZERO: assert property ( // [R27]
		!ctrlStatus_q[CSR_FORCE_RELOAD_BIT])
		else $error("force reload bit read back as one");
	AST_CAP_LATCH: assert property ( // [R20]
		capEvent[0] && !capFlag[0]
		|=> captureVal0_q == $past(counter_q) && capFlag[0])
		else $error("capture did not latch counter");
	AST_CAP_BLOCK: assert property ( // [R22]
		capFlag[1] && !captureRd[1] |=> $stable(captureVal1_q) && capFlag[1])
		else $error("capture overwritten before read");
	AST_CAP_IRQ: assert property ( // [R23]
		capFlag[0] && captureCtrl_q[ICS_IE_LO] |=> captureIrq_q[0] && wakeUp_q)
		else $error("capture request not pending");
	AST_OVF_CLEAR: assert property ( // [R25]
		ctrlRd && !overflow |=> !ctrlStatus_q[CSR_OVF_BIT])
		else $error("status read did not clear overflow flag");
endmodule

// *** core/art_pkg.sv ***
// constants, field positions and carrier types of the auto-reload PWM timer
//
// How it works
// R01 - eight-bit counter steps on each prescaler tick
// R02 - software reads or writes live counter anytime
// R03 - overflow reloads counter, prescaler left alone
// R04 - prescaler tap divides by two to select
// R05 - input clock select picks core or external
// R06 - enable cleared freezes prescaler and counter
// R07 - reset clears counter, prescaler, selects core clock
// R08 - force reload or counter write clears prescaler; force reload here acts only when written together with enable set
// R09 - prescaler has no software access path
// R10 - hidden compares reload from duty at overflow
// R11 - PWM generation stops during halt mode
// R12 - output enable drives pin push-pull
// R13 - PWM period is 256 minus reload value
// R14 - overflow sets polarity level, compare restores
// R15 - software keeps duty above reload value
// R16 - reload zero gives full 1/256 resolution
// R17 - overflow sets sticky flag, optional interrupt
// R18 - event count is 256 minus reload value
// R19 - software clears enable before entering halt
// R20 - capture edge latches counter, sets flag
// R21 - per-channel capture edge select bit
// R22 - capture blocked until value read, read clears
// R23 - capture interrupt pending while flag enabled
// R24 - timer events wake MCU from wait, halt
// R25 - status read clears overflow flag
// R26 - polarity zero: high at or below compare
// R27 - force reload bit always reads zero
// R28 - external pins synchronised before edge detection
package art_pkg;

	// ----------------------------------------------------------------
	// control/status register fields
	// ----------------------------------------------------------------
	localparam int CSR_INCLK_BIT = 7;
	localparam int CSR_DIV_HI = 6;
	localparam int CSR_DIV_LO = 4;
	localparam int CSR_TCE_BIT = 3;
	localparam int CSR_FORCE_RELOAD_BIT = 2;
	localparam int CSR_OIE_BIT = 1;
	localparam int CSR_OVF_BIT = 0;

	// ----------------------------------------------------------------
	// capture control/status and PWM control fields
	// ----------------------------------------------------------------
	localparam int ICS_EDGE_LO = 4;
	localparam int ICS_IE_LO = 2;
	localparam int ICS_FLAG_LO = 0;
	localparam int PWMC_OE_LO = 4;
	localparam int PWMC_POL_LO = 0;

	// ----------------------------------------------------------------
	// reset values and counter limits
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [6:0] PRE_RESET = 7'h00;
	localparam logic [7:0] CNT_TOP = 8'hFF;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic [7:0] data;
	} reg_wr_t;

	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe;
	} pwm_pins_t;

endpackage

// *** core/edge_sync.sv ***
// two-flop synchroniser with rise and fall detection for one pin
`timescale 1ns/1ps
module edge_sync (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// pin side
	input wire logic pinIn,
	// detected edges, one-cycle pulses
	output logic rise,
	output logic fall
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// first stage feeds only the second stage [R28]
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise = sync_q & ~last_q;
	assign fall = ~sync_q & last_q;
endmodule

// *** tb/art_pin_model.sv ***
// pin-side partner: external clock, capture pins and PWM watcher
`timescale 1ns/1ps
module art_pin_model (
	// clock
	input wire logic core_clk,
	// pins
	input wire art_pkg::pwm_pins_t pwmPins_q,
	output logic extClkIn,
	output logic [1:0] captureIn
);
	import art_pkg::*;
	int hiCnt [4];
	initial begin
		extClkIn = 1'b0;
		captureIn = 2'b00;
	end
	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	// pulses far slower than the three-cycle synchroniser path
	task automatic extPulse(input int n);
		repeat (n) begin
			repeat (4) @(posedge core_clk);
			#1 extClkIn = 1'b1;
			repeat (4) @(posedge core_clk);
			#1 extClkIn = 1'b0;
		end
		repeat (6) @(posedge core_clk);
		#1;
	endtask
	task automatic capDrive(input int ch, input logic lvl);
		@(posedge core_clk);
		#1 captureIn[ch] = lvl;
		repeat (6) @(posedge core_clk);
		#1;
	endtask
	// high time over a window; phase-free when window is one period
	task automatic measure(input int n);
		for (int i = 0; i < 4; i++) hiCnt[i] = 0;
		repeat (n) begin
			@(posedge core_clk);
			#2;
			for (int i = 0; i < 4; i++) hiCnt[i] += int'(pwmPins_q.level[i]);
		end
	endtask
endmodule

// *** tb/auto_reload_pwm_timer_tb.sv ***
// self-checking bench for the auto-reload PWM timer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("[ERR] %s exp %0h got %0h", nm, e, g); \
	end \
end
module auto_reload_pwm_timer_tb;
	import art_pkg::*;
	logic core_clk, sys_rst, ctrlRd, haltMode, extClkIn, overflowIrq_q;
	logic wakeUp_q;
	reg_wr_t ctrlWr, counterWr, reloadWr, pwmCtrlWr, captureCtrlWr;
	logic [3:0] dutyWrEn;
	logic [7:0] dutyWrData, ctrlStatus_q, counter_q, autoReload_q;
	logic [7:0] pwmCtrl_q, captureCtrl_q, captureVal0_q, captureVal1_q;
	logic [1:0] captureRd, captureIn, captureIrq_q;
	pwm_pins_t pwmPins_q;
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	auto_reload_pwm_timer dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
		.ctrlWr(ctrlWr), .counterWr(counterWr), .reloadWr(reloadWr),
		.pwmCtrlWr(pwmCtrlWr), .captureCtrlWr(captureCtrlWr),
		.dutyWrEn(dutyWrEn), .dutyWrData(dutyWrData), .ctrlRd(ctrlRd),
		.captureRd(captureRd), .haltMode(haltMode), .extClkIn(extClkIn),
		.captureIn(captureIn), .ctrlStatus_q(ctrlStatus_q),
		.counter_q(counter_q), .autoReload_q(autoReload_q),
		.pwmCtrl_q(pwmCtrl_q), .captureCtrl_q(captureCtrl_q),
		.captureVal0_q(captureVal0_q), .captureVal1_q(captureVal1_q),
		.pwmPins_q(pwmPins_q), .overflowIrq_q(overflowIrq_q),
		.captureIrq_q(captureIrq_q), .wakeUp_q(wakeUp_q));
	art_pin_model pin_u (.core_clk(core_clk), .pwmPins_q(pwmPins_q),
		.extClkIn(extClkIn), .captureIn(captureIn));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// whole run needs about 1600 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			end_sim();
		end
	end
	// ------------------------------------------------------------
	// access tasks: wr 0 ctrl, 1 counter, 2 reload, 3 pwm, 4 capture,
	// 5..8 duty of channel 0..3; rd 0 ctrl status, 1..2 capture channel 0..1
	// ------------------------------------------------------------
	task automatic wr(input int sel, input logic [7:0] d);
		reg_wr_t w;
		w.en = 1'b1;
		w.data = d;
		@(posedge core_clk);
		#1;
		case (sel)
			0: ctrlWr = w;
			1: counterWr = w;
			2: reloadWr = w;
			3: pwmCtrlWr = w;
			4: captureCtrlWr = w;
			default: begin
				dutyWrEn = 4'h1 << (sel - 5);
				dutyWrData = d;
			end
		endcase
		@(posedge core_clk);
		#1;
		ctrlWr.en = 1'b0;
		counterWr.en = 1'b0;
		reloadWr.en = 1'b0;
		pwmCtrlWr.en = 1'b0;
		captureCtrlWr.en = 1'b0;
		dutyWrEn = 4'h0;
	endtask
	task automatic rd(input int sel);
		@(posedge core_clk);
		#1;
		if (sel == 0) ctrlRd = 1'b1;
		else captureRd[sel-1] = 1'b1;
		@(posedge core_clk);
		#1;
		ctrlRd = 1'b0;
		captureRd = 2'b00;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic end_sim();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{ctrlWr, counterWr, reloadWr, pwmCtrlWr, captureCtrlWr} = '0;
		{dutyWrEn, dutyWrData, ctrlRd, captureRd, haltMode} = '0;
		sys_rst = 1'b1;
		repeat (5) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		`CHK("counter", 8'h00, counter_q);
		`CHK("ctrl", 8'h00, ctrlStatus_q);
		`CHK("pins", 8'h00, pwmPins_q);
		done("reset");
		for (int k = 0; k < 8; k++) begin
			wr(0, {1'b0, 3'(k), 4'h8});
			wr(1, 8'h10);
			tick(2 << k);
			`CHK("counter", 8'h12, counter_q);
		end
		done("divider");
		wr(2, 8'hC0);
		`CHK("reload", 8'hC0, autoReload_q);
		wr(0, 8'h0A);
		wr(1, 8'hC0);
		tick(64);
		`CHK("counter", 8'hC0, counter_q);
		tick(3);
		`CHK("ovf", 1'b1, ctrlStatus_q[0]);
		`CHK("ovfIrq", 1'b1, overflowIrq_q);
		`CHK("wake", 1'b1, wakeUp_q);
		rd(0);
		tick(2);
		`CHK("ovf", 1'b0, ctrlStatus_q[0]);
		`CHK("ovfIrq", 1'b0, overflowIrq_q);
		wr(2, 8'h80);
		wr(0, 8'h0C);
		`CHK("counter", 8'h80, counter_q);
		`CHK("force_reload", 1'b0, ctrlStatus_q[2]);
		wr(0, 8'h00);
		wr(1, 8'h37);
		tick(20);
		`CHK("counter", 8'h37, counter_q);
		done("overflow");
		wr(2, 8'h00);
		wr(5, 8'h40);
		wr(6, 8'h80);
		wr(7, 8'h20);
		wr(8, 8'hFF);
		wr(3, 8'hB2);
		wr(0, 8'h08);
		tick(300);
		pin_u.measure(256);
		`CHK("oe", 4'hB, pwmPins_q.oe);
		`CHK("pwmCtrl", 8'hB2, pwmCtrl_q);
		`CHK("hi0", 65, pin_u.hiCnt[0]);
		`CHK("hi1", 127, pin_u.hiCnt[1]);
		`CHK("hi2", 0, pin_u.hiCnt[2]);
		`CHK("hi3", 256, pin_u.hiCnt[3]);
		wr(3, 8'hB3);
		pin_u.measure(256);
		`CHK("hi0", 191, pin_u.hiCnt[0]);
		wr(0, 8'h00);
		wr(1, 8'h37);
		wr(8, 8'h10);
		tick(3);
		`CHK("level", 4'h8, pwmPins_q.level);
		haltMode = 1'b1;
		wr(0, 8'h08);
		wr(3, 8'hBB);
		tick(20);
		`CHK("counter", 8'h37, counter_q);
		`CHK("level", 4'h8, pwmPins_q.level);
		haltMode = 1'b0;
		done("pwm");
		wr(0, 8'h00);
		wr(1, 8'h5A);
		wr(4, 8'h1C);
		pin_u.capDrive(0, 1'b1);
		`CHK("cap0", 8'h5A, captureVal0_q);
		`CHK("capCtrl", 8'h1D, captureCtrl_q);
		`CHK("capIrq", 2'b01, captureIrq_q);
		wr(1, 8'h33);
		pin_u.capDrive(0, 1'b0);
		pin_u.capDrive(0, 1'b1);
		`CHK("cap0", 8'h5A, captureVal0_q);
		`CHK("capIrq", 2'b01, captureIrq_q);
		rd(1);
		tick(2);
		`CHK("capCtrl", 8'h1C, captureCtrl_q);
		`CHK("capIrq", 2'b00, captureIrq_q);
		pin_u.capDrive(0, 1'b0);
		pin_u.capDrive(0, 1'b1);
		`CHK("cap0", 8'h33, captureVal0_q);
		pin_u.capDrive(1, 1'b1);
		`CHK("flag1", 1'b0, captureCtrl_q[1]);
		pin_u.capDrive(1, 1'b0);
		`CHK("cap1", 8'h33, captureVal1_q);
		`CHK("flag1", 1'b1, captureCtrl_q[1]);
		done("capture");
		wr(2, 8'hFD);
		wr(0, 8'h88);
		wr(1, 8'hFD);
		rd(0);
		pin_u.extPulse(2);
		`CHK("counter", 8'hFF, counter_q);
		`CHK("ovf", 1'b0, ctrlStatus_q[0]);
		pin_u.extPulse(1);
		`CHK("counter", 8'hFD, counter_q);
		`CHK("ovf", 1'b1, ctrlStatus_q[0]);
		wr(0, 8'h00);
		done("events");
		end_sim();
	end
endmodule
